// *** src/drt_ctrl.sv ***
// Controller end: turnaround spacing and refresh scheduling with debt counter.
`timescale 1ns/1ps
`default_nettype none
module drt_ctrl #(
    parameter int TRFC_CYC = drt_pkg::DRT_TRFC_CYC,
    parameter int TREFI_CYC = drt_pkg::DRT_TREFI_CYC
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // User requests.
    input wire logic req_valid_i,
    input wire drt_pkg::drt_cmd_t req_cmd_i,
    input wire logic [2:0] req_bank_i,
    input wire logic [15:0] req_addr_i,
    input wire logic req_bc4_i,
    input wire logic req_otf_i,
    input wire drt_pkg::drt_mode_t mode_i,
    output logic req_ready_o,
    output logic ref_issued_o,
    output logic signed [6:0] debt_o,
    // Command pins.
    drt_if.ctrl link
);
    import drt_pkg::*;

    typedef struct packed {
        logic [DRT_CNT_W-1:0] r2w;
        logic [DRT_CNT_W-1:0] w2r_l;
        logic [DRT_CNT_W-1:0] w2r_s;
        logic wr_bg;
        logic [DRT_CNT_W-1:0] rp;
        logic [DRT_CNT_W-1:0] rfc;
        logic [DRT_CNT_W-1:0] refi;
        logic signed [6:0] debt;
        logic [7:0] open;
        logic [4:0] pins;
        logic [2:0] bk;
        logic issued;
        logic ready;
    } drt_ctl_st_t;

    drt_ctl_st_t st_reg;
    drt_ctl_st_t st_next;
    logic ok;
    logic signed [6:0] lim;
    logic [DRT_CNT_W-1:0] wbl_half;

    always_comb begin
        st_next = st_reg;
        lim = signed'(drt_limit(mode_i));
        ok = 1'b0;
        // RULE_05 - write burst length.
        wbl_half = DRT_CNT_W'((req_bc4_i && !req_otf_i) ? DRT_BC4 / 2 : DRT_BL8 / 2);
        st_next.issued = 1'b0;
        st_next.pins = 5'h00;
        if (st_reg.r2w != '0) st_next.r2w = st_reg.r2w - 1'b1;
        if (st_reg.w2r_l != '0) st_next.w2r_l = st_reg.w2r_l - 1'b1;
        if (st_reg.w2r_s != '0) st_next.w2r_s = st_reg.w2r_s - 1'b1;
        if (st_reg.rp != '0) st_next.rp = st_reg.rp - 1'b1;
        if (st_reg.rfc != '0) st_next.rfc = st_reg.rfc - 1'b1;
        // RULE_17 RULE_22 - debt per interval.
        if (st_reg.refi >= (DRT_CNT_W'(TREFI_CYC) >> mode_i) - 1'b1) begin
            st_next.refi = '0;
            if (st_reg.debt < lim) st_next.debt = st_reg.debt + 7'sh01;
        end else begin
            st_next.refi = st_reg.refi + 1'b1;
        end
        // RULE_16 - deselect during blackout.
        if (st_reg.rfc == '0 && req_valid_i) begin
            case (req_cmd_i)
                DRT_CMD_RD: begin
                    // RULE_02 RULE_03 - write to read.
                    ok = (req_bank_i[2] == st_reg.wr_bg) ? st_reg.w2r_l == '0
                                                         : st_reg.w2r_s == '0;
                    // RULE_01 RULE_04 - read burst length.
                    if (ok) st_next.r2w = req_bc4_i ? DRT_RD2WR_BC4 : DRT_RD2WR_BL8;
                end
                DRT_CMD_WR: begin
                    // RULE_01 - write after read.
                    ok = st_reg.r2w == '0;
                    if (ok) begin
                        st_next.wr_bg = req_bank_i[2];
                        st_next.w2r_l = DRT_CNT_W'(DRT_CWL + DRT_TWTR_L) + wbl_half;
                        st_next.w2r_s = DRT_CNT_W'(DRT_CWL + DRT_TWTR_S) + wbl_half;
                    end
                end
                DRT_CMD_REF: begin
                    // RULE_13 RULE_20 RULE_21 - idle, pull-in bound.
                    ok = st_reg.open == '0 && st_reg.rp == '0 && st_reg.debt > -lim;
                    if (ok) begin
                        st_next.rfc = DRT_CNT_W'(TRFC_CYC);
                        st_next.debt = st_next.debt - 7'sh01;
                        st_next.issued = 1'b1;
                    end
                end
                DRT_CMD_PRE: begin
                    ok = 1'b1;
                    st_next.open = '0;
                    st_next.rp = DRT_CNT_W'(DRT_TRP);
                end
                DRT_CMD_ACT: begin
                    // RULE_18 RULE_19 - postpone limit.
                    ok = st_reg.debt < lim;
                    if (ok) st_next.open[req_bank_i] = 1'b1;
                end
                default: ok = 1'b1;
            endcase
            if (ok) begin
                st_next.bk = req_bank_i;
                case (req_cmd_i)
                    DRT_CMD_ACT: st_next.pins = 5'h18;
                    DRT_CMD_RD: st_next.pins = 5'h12;
                    DRT_CMD_WR: st_next.pins = 5'h13;
                    DRT_CMD_PRE: st_next.pins = 5'h15;
                    // RULE_12 - refresh encoding.
                    DRT_CMD_REF: st_next.pins = 5'h16;
                    default: st_next.pins = 5'h00;
                endcase
            end
        end
        st_next.ready = st_next.rfc == '0;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Pins are held active high {cs, act, ras, cas, we} so the reset state is a deselect.
    assign link.cs_n = ~st_reg.pins[4];
    assign link.act_n = ~st_reg.pins[3];
    assign link.ras_n = ~st_reg.pins[2];
    assign link.cas_n = ~st_reg.pins[1];
    assign link.we_n = ~st_reg.pins[0];
    assign link.bank = st_reg.bk[1:0];
    assign link.bank_group = st_reg.bk[2];
    // Address bit 10 makes every precharge close all banks.
    assign link.addr = {5'h00, st_reg.pins == 5'h15, 10'h000};
    assign link.burst_otf = 1'b0;
    assign link.strobe_late = 1'b0;
    assign link.strobe_err = 1'b0;
    assign req_ready_o = st_reg.ready;
    assign ref_issued_o = st_reg.issued;
    assign debt_o = st_reg.debt;
endmodule : drt_ctrl
`default_nettype wire

// *** shared/drt_pkg.sv ***
// Package: command encodings, timing counts and types shared by both ends.
// Functional notes
// RULE_01 - Write after read: CL-CWL+read_burst_length/2+1+tWPRE.
// RULE_02 - Same-group read after write: CWL+write_burst_length/2+tWTR_L.
// RULE_03 - Other-group read after write: CWL+write_burst_length/2+tWTR_S.
// RULE_04 - Read burst length 8 or 4.
// RULE_05 - Write burst length 4 only fixed BC4.
// RULE_06 - Bad data timing corrupts only that write.
// RULE_07 - Tolerance needs CRC and OTF disabled.
// RULE_08 - Offending strobe within six edges of latency.
// RULE_09 - Read accepted after offending write.
// RULE_10 - Further writes accepted; data may be wrong.
// RULE_11 - All banks idle restores correct writes; the device clears suspicion only on a precharge that leaves all banks idle.
// RULE_12 - Refresh decode: CS/RAS/CAS low, WE/ACT high.
// RULE_13 - Banks idle tRP before refresh.
// RULE_14 - Refresh rows from internal counter.
// RULE_15 - Refresh ends with all banks idle.
// RULE_16 - Only deselect until tRFC elapses.
// RULE_17 - One refresh command per refresh due.
// RULE_18 - Postpone at most 8/16/32 refreshes.
// RULE_19 - Refresh gap at most 9/17/33 intervals.
// RULE_20 - Pull in at most 8/16/32 refreshes.
// RULE_21 - At most 16/32/64 refreshes per window.
// RULE_22 - Signed refresh debt counter within limits.
`default_nettype none
package drt_pkg;
    typedef enum logic [2:0] {
        DRT_CMD_DES,
        DRT_CMD_ACT,
        DRT_CMD_RD,
        DRT_CMD_WR,
        DRT_CMD_PRE,
        DRT_CMD_REF
    } drt_cmd_t;

    typedef enum logic [1:0] {
        DRT_MODE_1X,
        DRT_MODE_2X,
        DRT_MODE_4X
    } drt_mode_t;

    localparam int DRT_CLK_MHZ = 20;
    localparam int DRT_CL = 22;
    localparam int DRT_CWL = 16;
    localparam int DRT_TWPRE = 1;
    localparam int DRT_TWTR_L = 12;
    localparam int DRT_TWTR_S = 4;
    localparam int DRT_TRP = 22;
    localparam int DRT_TCCD_L = 8;
    localparam int DRT_TCCD_S = 4;
    localparam int DRT_TRFC_NS = 350;
    localparam int DRT_TRFC_CYC = (DRT_TRFC_NS * DRT_CLK_MHZ + 999) / 1000;
    localparam int DRT_TREFI_NS = 7800;
    localparam int DRT_TREFI_CYC = (DRT_TREFI_NS * DRT_CLK_MHZ) / 1000;
    localparam int DRT_BL8 = 8;
    localparam int DRT_BC4 = 4;
    localparam int DRT_POST_1X = 8;
    localparam int DRT_STROBE_WIN = 6;
    localparam int DRT_ROW_W = 16;
    localparam int DRT_CNT_W = 16;

    localparam logic [DRT_CNT_W-1:0] DRT_RD2WR_BL8 =
        DRT_CNT_W'(DRT_CL - DRT_CWL + DRT_BL8 / 2 + 1 + DRT_TWPRE);
    localparam logic [DRT_CNT_W-1:0] DRT_RD2WR_BC4 =
        DRT_CNT_W'(DRT_CL - DRT_CWL + DRT_BC4 / 2 + 1 + DRT_TWPRE);

    // Refresh limit scales with the granularity mode: 8, 16 or 32.
    function automatic logic [6:0] drt_limit(input drt_mode_t mode);
        case (mode)
            DRT_MODE_2X: drt_limit = 7'(DRT_POST_1X * 2);
            DRT_MODE_4X: drt_limit = 7'(DRT_POST_1X * 4);
            default: drt_limit = 7'(DRT_POST_1X);
        endcase
    endfunction : drt_limit

    // Refresh interval in cycles for the mode.
    function automatic logic [DRT_CNT_W-1:0] drt_refi(input drt_mode_t mode);
        case (mode)
            DRT_MODE_2X: drt_refi = DRT_CNT_W'(DRT_TREFI_CYC / 2);
            DRT_MODE_4X: drt_refi = DRT_CNT_W'(DRT_TREFI_CYC / 4);
            default: drt_refi = DRT_CNT_W'(DRT_TREFI_CYC);
        endcase
    endfunction : drt_refi
endpackage : drt_pkg
`default_nettype wire

// *** shared/drt_if.sv ***
// Interface: command/address/strobe pins between controller and memory device.
`timescale 1ns/1ps
`default_nettype none
interface drt_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic act_n;
    logic [1:0] bank;
    logic bank_group;
    logic [15:0] addr;
    logic burst_otf;
    logic strobe_late;
    logic strobe_err;

    modport ctrl (
        output cs_n, ras_n, cas_n, we_n, act_n, bank, bank_group, addr, burst_otf,
        output strobe_late, strobe_err
    );
    modport dev (
        input cs_n, ras_n, cas_n, we_n, act_n, bank, bank_group, addr, burst_otf,
        input strobe_late, strobe_err
    );
endinterface : drt_if
`default_nettype wire

// *** src/drt_device.sv ***
// Memory device end: command decode, refresh counter, write violation containment.
`timescale 1ns/1ps
`default_nettype none
module drt_device #(
    parameter int TRFC_CYC = drt_pkg::DRT_TRFC_CYC
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Command pins.
    drt_if.dev link,
    // Configuration.
    input wire logic crc_en_i,
    input wire logic otf_en_i,
    // Status.
    output logic refresh_busy_o,
    output logic [drt_pkg::DRT_ROW_W-1:0] refresh_row_o,
    output logic [7:0] banks_open_o,
    output logic write_suspect_o,
    output logic hang_o
);
    import drt_pkg::*;

    typedef struct packed {
        logic [DRT_CNT_W-1:0] rfc_cnt;
        logic [DRT_ROW_W-1:0] row;
        logic [7:0] open;
        logic suspect;
        logic hang;
        logic busy;
    } drt_dev_st_t;

    drt_dev_st_t st_reg;
    drt_dev_st_t st_next;
    drt_cmd_t cmd;
    logic [2:0] bidx;

    always_comb begin
        cmd = DRT_CMD_DES;
        bidx = {link.bank_group, link.bank};
        if (!link.cs_n) begin
            if (!link.act_n) begin
                cmd = DRT_CMD_ACT;
            // RULE_12 - refresh decode pattern.
            end else if (!link.ras_n && !link.cas_n && link.we_n) begin
                cmd = DRT_CMD_REF;
            end else if (link.ras_n && !link.cas_n && link.we_n) begin
                cmd = DRT_CMD_RD;
            end else if (link.ras_n && !link.cas_n && !link.we_n) begin
                cmd = DRT_CMD_WR;
            end else if (!link.ras_n && link.cas_n && !link.we_n) begin
                cmd = DRT_CMD_PRE;
            end
        end
    end

    always_comb begin
        st_next = st_reg;
        if (st_reg.rfc_cnt != '0) begin
            st_next.rfc_cnt = st_reg.rfc_cnt - 1'b1;
        end
        case (cmd)
            DRT_CMD_ACT: begin
                st_next.open[bidx] = 1'b1;
            end
            DRT_CMD_PRE: begin
                if (link.addr[10]) begin
                    st_next.open = '0;
                end else begin
                    st_next.open[bidx] = 1'b0;
                end
            end
            DRT_CMD_WR: begin
                // RULE_06 RULE_09 RULE_10 - flag data only.
                if (link.strobe_err) begin
                    st_next.suspect = 1'b1;
                    // RULE_07 - needs CRC, OTF off.
                    // RULE_08 - six edge window.
                    if (crc_en_i || otf_en_i || link.strobe_late) begin
                        st_next.hang = 1'b1;
                    end
                end
                // Auto-precharge closes the bank.
                if (link.addr[10]) begin
                    st_next.open[bidx] = 1'b0;
                end
            end
            DRT_CMD_REF: begin
                // RULE_12 - start refresh cycle.
                st_next.rfc_cnt = DRT_CNT_W'(TRFC_CYC);
                // RULE_14 - internal row counter.
                st_next.row = st_reg.row + 1'b1;
                // RULE_15 - all banks idle.
                st_next.open = '0;
            end
            default: begin
            end
        endcase
        // RULE_11 - a precharge leaving all banks idle clears suspicion.
        if (st_next.open == '0 && cmd == DRT_CMD_PRE) begin
            st_next.suspect = 1'b0;
        end
        st_next.busy = st_next.rfc_cnt != '0;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign refresh_busy_o = st_reg.busy;
    assign refresh_row_o = st_reg.row;
    assign banks_open_o = st_reg.open;
    assign write_suspect_o = st_reg.suspect;
    assign hang_o = st_reg.hang;
endmodule : drt_device
`default_nettype wire

// *** sim/drt_checker.sv ***
// Checker: command spacing seen on the pins between the two ends.
`timescale 1ns/1ps
`default_nettype none
module drt_checker #(
    parameter int TRFC_CYC = 7
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Command pins.
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic act_n,
    input wire logic bank_group,
    input wire logic strobe_late
);
    import drt_pkg::*;
    // Shortest legal bursts give the smallest spacing the pins may show.
    localparam int RW = DRT_CL - DRT_CWL + DRT_BC4 / 2 + 1 + DRT_TWPRE;
    localparam int WRL = DRT_CWL + DRT_BC4 / 2 + DRT_TWTR_L;
    localparam int WRS = DRT_CWL + DRT_BC4 / 2 + DRT_TWTR_S;
    localparam int TRP = DRT_TRP;
    logic [4:0] pins;
    logic [7:0] rd_c, wr_c, pre_c, rf_c;
    logic rd, wr, pr, rf, ac, wr_bg, open_q;
    assign pins = {cs_n, act_n, ras_n, cas_n, we_n};
    assign rd = pins == 5'h0D;
    assign wr = pins == 5'h0C;
    assign pr = pins == 5'h0A;
    assign rf = pins == 5'h09;
    assign ac = pins[4:3] == 2'h0;
    ////////////////////////////////////////
    // Cycles since each read, write, precharge and refresh, saturating so old history reads as far away.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rd_c <= 8'hFF;
            wr_c <= 8'hFF;
            pre_c <= 8'hFF;
            rf_c <= 8'hFF;
            wr_bg <= 1'h0;
            open_q <= 1'h0;
        end else begin
            rd_c <= rd ? 8'h01 : rd_c + 8'(rd_c != 8'hFF);
            wr_c <= wr ? 8'h01 : wr_c + 8'(wr_c != 8'hFF);
            pre_c <= pr ? 8'h01 : pre_c + 8'(pre_c != 8'hFF);
            rf_c <= rf ? 8'h01 : rf_c + 8'(rf_c != 8'hFF);
            if (wr) begin
                wr_bg <= bank_group;
            end
            open_q <= ac | (open_q & ~pr);
        end
    end
    ////////////////////////////////////////
    default clocking dcb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    sequence s_one;
        !cs_n ##1 cs_n;
    endsequence
    cmd_one_cycle_a: assert property (!cs_n |-> s_one)
        else $error("command held over one cycle");
    ref_quiet_a: assert property (!cs_n |-> rf_c >= 8'(TRFC_CYC))
        else $error("command inside refresh blackout");
    rd_to_wr_a: assert property (wr |-> rd_c >= 8'(RW))
        else $error("write too soon after read");
    wr_rd_same_a: assert property (rd && bank_group == wr_bg |-> wr_c >= 8'(WRL))
        else $error("read too soon after write in group");
    wr_rd_diff_a: assert property (rd && bank_group != wr_bg |-> wr_c >= 8'(WRS))
        else $error("read too soon after write across groups");
    ref_trp_a: assert property (rf |-> pre_c >= 8'(TRP))
        else $error("refresh before precharge time");
    ref_idle_a: assert property (rf |-> !open_q)
        else $error("refresh with a bank open");
    strobe_ok_a: assert property (!strobe_late)
        else $error("strobe outside window");
endmodule : drt_checker
`default_nettype wire

// *** sim/drt_tb.sv ***
// Testbench: controller and device joined, plus a device driven directly.
`timescale 1ns/1ps
`default_nettype none
module drt_tb;
    import drt_pkg::*;
    localparam int TRFC = 7;
    localparam int TREFI = 4000;
    logic clk_sys_i, reset_i, req_valid_i, req_bc4_i, req_otf_i, crc_en_i, otf_en_i;
    drt_cmd_t req_cmd_i;
    drt_mode_t mode_i;
    logic [2:0] req_bank_i;
    logic req_ready_o, ref_issued_o, busy, hang, bbusy, bsusp, bhang;
    logic signed [6:0] debt_o;
    logic [15:0] row, brow;
    logic [7:0] open, bopen;
    logic [4:0] cpins;
    logic [26:0] bpins;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    drt_if i_drt_if ();
    drt_if i_bad_if ();
    assign cpins = {i_drt_if.cs_n, i_drt_if.act_n, i_drt_if.ras_n, i_drt_if.cas_n,
        i_drt_if.we_n};
    assign {i_bad_if.cs_n, i_bad_if.act_n, i_bad_if.ras_n, i_bad_if.cas_n, i_bad_if.we_n,
        i_bad_if.bank_group, i_bad_if.bank, i_bad_if.burst_otf, i_bad_if.addr,
        i_bad_if.strobe_err, i_bad_if.strobe_late} = bpins;
    drt_ctrl #(.TRFC_CYC(TRFC), .TREFI_CYC(TREFI)) i_drt_ctrl (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .req_bank_i(req_bank_i), .req_addr_i(16'hFFFF), .req_bc4_i(req_bc4_i),
        .req_otf_i(req_otf_i), .mode_i(mode_i), .req_ready_o(req_ready_o),
        .ref_issued_o(ref_issued_o), .debt_o(debt_o), .link(i_drt_if.ctrl));
    drt_device #(.TRFC_CYC(TRFC)) i_drt_device (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .link(i_drt_if.dev), .crc_en_i(crc_en_i), .otf_en_i(otf_en_i),
        .refresh_busy_o(busy), .refresh_row_o(row), .banks_open_o(open),
        .write_suspect_o(), .hang_o(hang));
    drt_device #(.TRFC_CYC(TRFC)) i_drt_device2 (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .link(i_bad_if.dev), .crc_en_i(crc_en_i), .otf_en_i(otf_en_i),
        .refresh_busy_o(bbusy), .refresh_row_o(brow), .banks_open_o(bopen),
        .write_suspect_o(bsusp), .hang_o(bhang));
    drt_checker #(.TRFC_CYC(TRFC)) i_drt_checker (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .cs_n(i_drt_if.cs_n), .ras_n(i_drt_if.ras_n),
        .cas_n(i_drt_if.cas_n), .we_n(i_drt_if.we_n), .act_n(i_drt_if.act_n),
        .bank_group(i_drt_if.bank_group), .strobe_late(i_drt_if.strobe_late));
    ////////////////////////////////////////
    initial begin
        clk_sys_i = 1'h0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("Compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic do_reset;
        @(negedge clk_sys_i);
        reset_i = 1'h1;
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'h0;
    endtask : do_reset
    function automatic logic [4:0] enc(input drt_cmd_t c);
        case (c)
            DRT_CMD_ACT: return 5'h07;
            DRT_CMD_RD: return 5'h0D;
            DRT_CMD_WR: return 5'h0C;
            DRT_CMD_PRE: return 5'h0A;
            DRT_CMD_REF: return 5'h09;
            default: return 5'h1F;
        endcase
    endfunction : enc
    // Holds the request until the pins show it, or gives up after lim cycles.
    task automatic send(input drt_cmd_t c, input logic [2:0] b, input int lim, output bit ok);
        ok = 1'h0;
        @(negedge clk_sys_i);
        req_valid_i = 1'h1;
        req_cmd_i = c;
        req_bank_i = b;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge clk_sys_i);
            ok = c == DRT_CMD_ACT ? cpins[4:3] === 2'h0 : cpins === enc(c);
        end
        req_valid_i = 1'h0;
    endtask : send
    task automatic go(input drt_cmd_t c, input logic [2:0] b, output int t);
        bit ok;
        send(c, b, 300, ok);
        t = cyc;
        if (!ok) begin
            error_cnt++;
            $display("Error %s expected issued seen timeout", c.name());
            report_and_stop();
        end
    endtask : go
    task automatic pin(input drt_cmd_t c, input logic [1:0] sv);
        @(negedge clk_sys_i);
        bpins = {enc(c), 4'h0, 16'hFFFF, sv};
        @(negedge clk_sys_i);
        bpins = {5'h1F, 4'h0, 16'hFFFF, sv};
        repeat (30) @(negedge clk_sys_i);
        bpins[1:0] = 2'h0;
    endtask : pin
    ////////////////////////////////////////
    task automatic t_pull(input drt_mode_t m);
        bit ok;
        int n;
        mode_i = m;
        do_reset();
        n = 0;
        ok = 1'h1;
        while (ok && n < 40) begin
            send(DRT_CMD_REF, 3'h0, 30, ok);
            n = n + int'(ok);
            if (ok) chk("issued", 1'h1, ref_issued_o);
            @(negedge clk_sys_i);
            if (ok) chk("ready", 1'h0, req_ready_o);
            if (ok) chk("busy", 1'h1, busy);
        end
        chk("pull count", 16'(8 << m), 16'(n));
        chk("debt", 7'(-(8 << m)), debt_o);
        chk("row", 16'(n), row);
        chk("banks", 8'h00, open);
    endtask : t_pull
    task automatic t_turn;
        drt_cmd_t a[7] = '{DRT_CMD_RD, DRT_CMD_RD, DRT_CMD_WR, DRT_CMD_WR, DRT_CMD_WR,
            DRT_CMD_WR, DRT_CMD_RD};
        int g[7] = '{12, 10, 32, 24, 30, 32, 10};
        bit [6:0] bc4 = 7'h72;
        bit [6:0] otf = 7'h60;
        bit [6:0] far = 7'h0A;
        int t1, t2;
        go(DRT_CMD_ACT, 3'h0, t1);
        go(DRT_CMD_ACT, 3'h4, t1);
        for (int i = 0; i < 7; i++) begin
            req_bc4_i = bc4[i];
            req_otf_i = otf[i];
            go(a[i], 3'h0, t1);
            go(a[i] == DRT_CMD_RD ? DRT_CMD_WR : DRT_CMD_RD, {far[i], 2'h0}, t2);
            chk("gap", 1'h1, 16'(t2 - t1 >= g[i]));
        end
        chk("hang", 1'h0, hang);
    endtask : t_turn
    task automatic t_viol;
        do_reset();
        pin(DRT_CMD_ACT, 2'h0);
        pin(DRT_CMD_WR, 2'h2);
        chk("suspect", 1'h1, bsusp);
        pin(DRT_CMD_RD, 2'h0);
        pin(DRT_CMD_WR, 2'h0);
        chk("hang", 1'h0, bhang);
        pin(DRT_CMD_PRE, 2'h0);
        chk("suspect", 1'h0, bsusp);
        pin(DRT_CMD_REF, 2'h0);
        chk("row", 16'h0001, brow);
        chk("busy", 1'h0, bbusy);
        chk("banks", 8'h00, bopen);
        pin(DRT_CMD_ACT, 2'h0);
        pin(DRT_CMD_WR, 2'h3);
        chk("hang", 1'h1, bhang);
        do_reset();
        otf_en_i = 1'h1;
        pin(DRT_CMD_ACT, 2'h0);
        pin(DRT_CMD_WR, 2'h2);
        chk("hang", 1'h1, bhang);
        otf_en_i = 1'h0;
        do_reset();
        crc_en_i = 1'h1;
        pin(DRT_CMD_ACT, 2'h0);
        pin(DRT_CMD_WR, 2'h2);
        chk("hang", 1'h1, bhang);
        crc_en_i = 1'h0;
    endtask : t_viol
    task automatic t_post;
        int t;
        mode_i = DRT_MODE_1X;
        do_reset();
        repeat (8 * TREFI + 20) @(negedge clk_sys_i);
        chk("debt", 7'h08, debt_o);
        go(DRT_CMD_REF, 3'h0, t);
        @(negedge clk_sys_i);
        chk("debt", 7'h07, debt_o);
    endtask : t_post
    ////////////////////////////////////////
    initial begin
        {reset_i, req_valid_i, req_bc4_i, req_otf_i, crc_en_i, otf_en_i} = 6'h20;
        req_cmd_i = DRT_CMD_DES;
        req_bank_i = 3'h0;
        mode_i = DRT_MODE_1X;
        bpins = {5'h1F, 22'h0};
        t_pull(DRT_MODE_1X);
        t_pull(DRT_MODE_2X);
        t_pull(DRT_MODE_4X);
        t_turn();
        t_viol();
        t_post();
        report_and_stop();
    end
endmodule : drt_tb
`default_nettype wire
